// ### rtl/drbc_ctrl.sv
`default_nettype none
module drbc_ctrl
	import drbc_pkg::*;
#(
	parameter int unsigned RELAY_CYCLES = RELAY_DELAY_CYC,
	parameter int unsigned CNT_W = STEP_CNT_W
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable_in,
	input wire logic run_cmd_in,
	input wire logic brake_cmd_in,
	input wire logic step_in,
	input wire logic dir_in,
	input wire logic step_mode,
	input wire logic current_nonzero,
	output logic drive_reset_ff,
	output logic relay_close_ff,
	output logic ready_ff,
	output logic commutate_ff,
	output logic [2:0] phase_low_on_ff,
	output logic brake_active_ff,
	output logic [CNT_W-1:0] step_pos_ff
);
	// elaboration-time guard: the timer and the step arithmetic are 32 bits wide
	if (RELAY_CYCLES < 2 || CNT_W < 2 || CNT_W > 32)
	begin : g_bad_params
		$error("drbc_ctrl: unsupported parameter values");
	end

	// two-stage synchronisers; stage one read only by stage two
	logic [4:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
	logic en_prev_ff, step_prev_ff, nxt_en_prev, nxt_step_prev;
	always_comb
	begin
		nxt_sync1 = {enable_in, run_cmd_in, brake_cmd_in, step_in, dir_in};
		nxt_sync2 = sync1_ff;
		nxt_en_prev = sync2_ff[4];
		nxt_step_prev = sync2_ff[1];
	end
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= 5'h0;
			sync2_ff <= 5'h0;
			en_prev_ff <= 1'b0;
			step_prev_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			en_prev_ff <= nxt_en_prev;
			step_prev_ff <= nxt_step_prev;
		end
	end

	logic en_s, run_s, brk_s, dir_s, en_fall, step_rise;
	assign en_s = sync2_ff[4];
	assign run_s = sync2_ff[3];
	assign brk_s = sync2_ff[2];
	assign dir_s = sync2_ff[0];
	assign en_fall = en_prev_ff && !en_s;
	assign step_rise = sync2_ff[1] && !step_prev_ff;

	function automatic logic [31:0] wrap_step(input logic [31:0] v, input logic up);
		wrap_step = up ? v + 32'h1 : v - 32'h1;
	endfunction

	// state and timer; step_mode is the only mode input and it gates only the step count
	drbc_state_t state_ff, nxt_state;
	logic [31:0] timer_ff, nxt_timer;
	logic [CNT_W-1:0] nxt_step_pos;
	logic nxt_reset, nxt_relay, nxt_ready, nxt_comm, nxt_brake;
	logic [2:0] nxt_phase;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_step_pos = step_pos_ff;
		case (state_ff)
			DRBC_HALT:
			begin
				nxt_timer = 32'h0;
				if (en_s && !en_fall)
					nxt_state = DRBC_INRUSH;
			end
			DRBC_INRUSH:
			begin
				nxt_timer = timer_ff + 32'h1;
				if (timer_ff == RELAY_CYCLES - 1)
					nxt_state = DRBC_COAST;
			end
			DRBC_COAST, DRBC_RUN, DRBC_BRAKE:
			begin
				if (brk_s)
					nxt_state = DRBC_BRAKE;
				else if (run_s)
					nxt_state = DRBC_RUN;
				else
					nxt_state = DRBC_COAST;
			end
			default: nxt_state = DRBC_HALT;
		endcase
		if (!en_s || en_fall)
		begin
			nxt_state = DRBC_HALT;
			nxt_timer = 32'h0;
			nxt_step_pos = STEP_CNT_RST[CNT_W-1:0];
		end
		else if (step_mode && step_rise)
			nxt_step_pos = CNT_W'(wrap_step(32'(step_pos_ff), dir_s));
		nxt_reset = (nxt_state == DRBC_HALT);
		nxt_relay = (nxt_state != DRBC_HALT) && (nxt_state != DRBC_INRUSH);
		nxt_ready = (nxt_state == DRBC_RUN);
		// commutation only with current demand; the brake forbids it
		nxt_comm = (nxt_state == DRBC_RUN) && current_nonzero;
		nxt_brake = (nxt_state == DRBC_BRAKE);
		nxt_phase = nxt_brake ? PHASE_SHORT : PHASE_OFF;
	end
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= DRBC_HALT;
			timer_ff <= 32'h0;
			step_pos_ff <= STEP_CNT_RST[CNT_W-1:0];
			drive_reset_ff <= 1'b1;
			relay_close_ff <= 1'b0;
			ready_ff <= 1'b0;
			commutate_ff <= 1'b0;
			brake_active_ff <= 1'b0;
			phase_low_on_ff <= PHASE_OFF;
		end
		else
		begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			step_pos_ff <= nxt_step_pos;
			drive_reset_ff <= nxt_reset;
			relay_close_ff <= nxt_relay;
			ready_ff <= nxt_ready;
			commutate_ff <= nxt_comm;
			brake_active_ff <= nxt_brake;
			phase_low_on_ff <= nxt_phase;
		end
	end

	sequence s_en_drop;
		sync2_ff[4] ##1 !sync2_ff[4];
	endsequence
	property p_fall_reset;
		@(posedge ref_clk) disable iff (!rst_n) s_en_drop |=> drive_reset_ff;
	endproperty
	a_fall_reset: assert property (p_fall_reset) else $error("no reset after enable fall");
	property p_low_no_current;
		@(posedge ref_clk) disable iff (!rst_n) !en_s |=> !commutate_ff && !relay_close_ff;
	endproperty
	a_low_no_current: assert property (p_low_no_current) else $error("current while disabled");
	property p_recover_rise;
		@(posedge ref_clk) disable iff (!rst_n) state_ff == DRBC_HALT && !en_s |=> state_ff == DRBC_HALT;
	endproperty
	a_recover_rise: assert property (p_recover_rise) else $error("left reset without enable");
	property p_relay_delay;
		@(posedge ref_clk) disable iff (!rst_n) $rose(relay_close_ff) |-> timer_ff == RELAY_CYCLES;
	endproperty
	a_relay_delay: assert property (p_relay_delay) else $error("relay closed early");
	property p_run_gated;
		@(posedge ref_clk) disable iff (!rst_n) ready_ff |-> relay_close_ff;
	endproperty
	a_run_gated: assert property (p_run_gated) else $error("run before relay");
	property p_coast;
		@(posedge ref_clk) disable iff (!rst_n) relay_close_ff && en_s && !run_s && !brk_s
			|=> !commutate_ff && phase_low_on_ff == PHASE_OFF;
	endproperty
	a_coast: assert property (p_coast) else $error("coast not applied");
	property p_brake_short;
		@(posedge ref_clk) disable iff (!rst_n) relay_close_ff && en_s && brk_s
			|=> brake_active_ff && !commutate_ff && phase_low_on_ff == PHASE_SHORT;
	endproperty
	a_brake_short: assert property (p_brake_short) else $error("brake not shorting");
	property p_step_dir;
		@(posedge ref_clk) disable iff (!rst_n) en_s && step_mode && step_rise && dir_s
			|=> step_pos_ff == $past(step_pos_ff) + 1'b1;
	endproperty
	a_step_dir: assert property (p_step_dir) else $error("step count wrong");
	// count wraps at both ends
	property p_step_down;
		@(posedge ref_clk) disable iff (!rst_n) en_s && step_mode && step_rise && !dir_s
			|=> step_pos_ff == $past(step_pos_ff) - 1'b1;
	endproperty
	a_step_down: assert property (p_step_down) else $error("step count down wrong");
	property p_step_hold;
		@(posedge ref_clk) disable iff (!rst_n) en_s && !(step_mode && step_rise) |=> $stable(step_pos_ff);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("count moved without step");
	property p_commutate;
		@(posedge ref_clk) disable iff (!rst_n) relay_close_ff && en_s && run_s && !brk_s && current_nonzero
			|=> commutate_ff && ready_ff;
	endproperty
	a_commutate: assert property (p_commutate) else $error("no commutation in run");
	property p_brake_first;
		@(posedge ref_clk) disable iff (!rst_n) relay_close_ff && en_s && brk_s && run_s |=> !ready_ff;
	endproperty
	a_brake_first: assert property (p_brake_first) else $error("run beat the brake");
	property p_halt_quiet;
		@(posedge ref_clk) disable iff (!rst_n) drive_reset_ff |-> !relay_close_ff && !ready_ff && !commutate_ff;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("outputs active in reset");
	property p_inrush_open;
		@(posedge ref_clk) disable iff (!rst_n) state_ff == DRBC_INRUSH |-> !relay_close_ff && !ready_ff;
	endproperty
	a_inrush_open: assert property (p_inrush_open) else $error("relay closed during delay");
endmodule
`default_nettype wire

// ### rtl/drbc_pkg.sv
`default_nettype none
package drbc_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned RELAY_DELAY_S = 3;
	localparam int unsigned RELAY_DELAY_CYC = RELAY_DELAY_S * CLK_HZ;
	localparam int unsigned STEP_CNT_W = 32;
	localparam logic [2:0] PHASE_OFF = 3'h0;
	localparam logic [2:0] PHASE_SHORT = 3'h7;
	localparam logic [31:0] STEP_CNT_RST = 32'h0;
	typedef enum logic [2:0]
	{
		DRBC_HALT = 3'h0,
		DRBC_INRUSH = 3'h1,
		DRBC_COAST = 3'h2,
		DRBC_RUN = 3'h3,
		DRBC_BRAKE = 3'h4
	} drbc_state_t;
endpackage
`default_nettype wire

// ### tb/drbc_ctrl_bench.sv
`default_nettype none
module drbc_ctrl_bench import drbc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst_n = 1'b0, en = 1'b0, run = 1'b0, brk = 1'b0;
	logic go = 1'b0, dir_req = 1'b0, smode = 1'b0, cnz = 1'b0;
	logic step_in, dir_in, d_rst, relay, ready, comm, brk_act;
	logic [2:0] ph3;
	logic [31:0] pos, exp_pos = 32'h0;
	int n_errors = 0, cmp_count = 0, seed = 32'hb32c, i, t;
	localparam int unsigned RELAY_SIM = 10;
	always #25 ref_clk = ~ref_clk;
	drbc_ctrl #(.RELAY_CYCLES(RELAY_SIM)) u_drbc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .enable_in(en),
		.run_cmd_in(run), .brake_cmd_in(brk), .step_in(step_in), .dir_in(dir_in), .step_mode(smode),
		.current_nonzero(cnz), .drive_reset_ff(d_rst), .relay_close_ff(relay), .ready_ff(ready),
		.commutate_ff(comm), .phase_low_on_ff(ph3), .brake_active_ff(brk_act), .step_pos_ff(pos));
	drbc_motion_model u_drbc_motion_model (.ref_clk(ref_clk), .go(go), .dir_req(dir_req),
		.step_in(step_in), .dir_in(dir_in));
	// expected count clears when enable drops, as the drive's counter does
	always @(posedge step_in or negedge en)
		if (!en)
			exp_pos <= 32'h0;
		else if (smode)
			exp_pos <= exp_pos + (dir_in ? 32'h1 : 32'hffffffff);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// generous: the sequence needs well under a thousand cycles
	initial
	begin
		#250000;
		n_errors++;
		summarize();
	end
	initial
	begin
		cyc(10);
		rst_n = 1'b1;
		cyc(5);
		chk("held", 32'h1, d_rst);
		en = 1'b1;
		run = 1'b1;
		cnz = 1'b1;
		t = 0;
		while (d_rst !== 1'b0 && t < 20)
		begin
			cyc(1);
			t++;
		end
		t = 0;
		while (relay !== 1'b1 && t < 30)
		begin
			chk("early", 32'h0, ready);
			cyc(1);
			t++;
		end
		chk("delay", 32'(RELAY_SIM), 32'(t));
		for (i = 0; i < 40; i++)
		begin
			{run, brk, cnz} = 3'($random(seed));
			cyc(4);
			chk("ready", run & ~brk, ready);
			chk("comm", run & ~brk & cnz, comm);
			chk("phases", brk ? 32'h7 : 32'h0, ph3);
			chk("brake", brk, brk_act);
		end
		brk = 1'b0;
		smode = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			dir_req = 1'($random(seed));
			go = 1'b1;
			cyc(1 + i * 5);
			go = 1'b0;
			cyc(8);
			chk("pos", exp_pos, pos);
		end
		go = 1'b1;
		en = 1'b0;
		cyc(4);
		chk("reset", 32'h1, d_rst);
		chk("ready", 32'h0, ready);
		chk("relay", 32'h0, relay);
		chk("pos", 32'h0, pos);
		chk("comm", 32'h0, comm);
		go = 1'b0;
		en = 1'b1;
		cyc(6);
		chk("relay", 32'h0, relay);
		cyc(10);
		chk("relay", 32'h1, relay);
		rst_n = 1'b0;
		cyc(2);
		chk("rst reset", 32'h1, d_rst);
		chk("rst relay", 32'h0, relay);
		chk("rst pos", 32'h0, pos);
		rst_n = 1'b1;
		cyc(6);
		chk("rst recover", 32'h0, d_rst);
		chk("rst relay", 32'h0, relay);
		cyc(10);
		chk("rst relay", 32'h1, relay);
		summarize();
	end
endmodule
`default_nettype wire

// ### tb/drbc_motion_model.sv
`default_nettype none
module drbc_motion_model
(
	input wire logic ref_clk,
	input wire logic go,
	input wire logic dir_req,
	output logic step_in,
	output logic dir_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph_ff = 2'h0;
	logic go_q = 1'b0, dir_q = 1'b0, step_ff = 1'b0, dir_ff = 1'b0;
	assign step_in = step_ff;
	assign dir_in = dir_ff;
	// requests latched on the rising edge, so the bench may change them on the falling one
	always @(posedge ref_clk)
	begin
		go_q <= go;
		dir_q <= dir_req;
	end
	// dir settles a cycle before the step rises, so each pulse sees one level
	always @(negedge ref_clk)
	begin
		ph_ff <= ph_ff + 2'h1;
		if (ph_ff == 2'h0)
			dir_ff <= dir_q;
		step_ff <= go_q & (ph_ff[0] ^ ph_ff[1]);
	end
endmodule
`default_nettype wire
